// ===== core/smbus_read_alert_timeout.sv
/*
  smbus slave read path: receive byte, block read with pec, alert response
  and bus timeout. scl/sda come from pins and are synchronised to clk here;
  the register array is a local stand-in for the monitor's data registers.
*/
// Overview of operation
// - read without command returns pointed register byte
// - command 0xA1 after write arms block read
// - block read sends byte count first
// - pec byte follows last data byte
// - pec is crc-8 polynomial 0x07
// - alert active: answer alert address with own address
// - lose arbitration during alert response read
// - alert released only when cause gone
// - 25 ms idle with timeout: release bus
// - config 0x03 bit 1 enables scl timeout
// - config 0x03 bit 2 enables sda timeout
// - first write byte loads register pointer, unless it is 0xA1
`timescale 1ns/1ps
module smbus_read_alert_timeout
  import smbus_read_pkg::*;
#(
  parameter int TIMEOUT_LIMIT = TIMEOUT_CYCLES,
  parameter logic [6:0] OWN_ADDR = 7'h5C // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // smbus pins
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // alert
  input wire logic alertCause,
  output logic alertOut,
  output logic alertOe,
  // status
  output logic [7:0] pointer,
  output logic timeoutEvent
);
  // ----------------------------------------------------------------
  // crc helper
  // ----------------------------------------------------------------
  function automatic logic [7:0] crcByte(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [1:0] sclSync_reg, sdaSync_reg;
  logic sclLast_reg, sdaLast_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclSync_reg <= 2'b11;
      sdaSync_reg <= 2'b11;
      sclLast_reg <= 1'b1;
      sdaLast_reg <= 1'b1;
    end else begin
      sclSync_reg <= {sclSync_reg[0], sclIn};
      sdaSync_reg <= {sdaSync_reg[0], sdaIn};
      sclLast_reg <= sclSync_reg[1];
      sdaLast_reg <= sdaSync_reg[1];
    end
  end
  logic scl, sda, sclRise, sclFall, startCond, stopCond;
  assign scl = sclSync_reg[1];
  assign sda = sdaSync_reg[1];
  assign sclRise = scl & ~sclLast_reg;
  assign sclFall = ~scl & sclLast_reg;
  assign startCond = scl & sclLast_reg & sdaLast_reg & ~sda;
  assign stopCond = scl & sclLast_reg & ~sdaLast_reg & sda;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  xfer_state_t state_reg, state_next;
  logic [2:0] bitCnt_reg, bitCnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] pointer_reg, pointer_next;
  logic [7:0] config_reg, config_next;
  logic [7:0] blockLen_reg, blockLen_next;
  logic [7:0] crc_reg, crc_next;
  logic [5:0] remain_reg, remain_next;
  logic armed_reg, armed_next;
  logic [1:0] wrIdx_reg, wrIdx_next;
  logic isRead_reg, isRead_next;
  logic ara_reg, ara_next;
  logic inBlock_reg, inBlock_next;
  logic sendPec_reg, sendPec_next;
  logic sdaDrive_reg, sdaDrive_next;
  logic skipFall_reg, skipFall_next;
  logic [31:0] idle_reg, idle_next;
  logic timeout_reg, timeout_next;
  logic [7:0] regs [256];
  logic regWr;
  logic [7:0] regWrData;

  // register array stand-in; block length and config are held in their own registers, not in it
  always_ff @(posedge clk) begin
    if (regWr) begin
      regs[pointer_reg] <= regWrData;
    end
  end

  // byte to send for a given read slot
  logic [7:0] txByte;
  always_comb begin
    if (ara_reg) begin
      txByte = {OWN_ADDR, 1'b1};
    end else if (sendPec_reg) begin
      txByte = crc_reg;
    end else if (inBlock_reg && remain_reg == 6'(blockLen_reg) + 6'd1) begin
      txByte = blockLen_reg;
    end else if (pointer_reg == BUS_TIMEOUT_CONFIG_OFFSET) begin
      txByte = config_reg;
    end else if (pointer_reg == BLOCK_LEN_OFFSET) begin
      txByte = blockLen_reg;
    end else begin
      txByte = regs[pointer_reg];
    end
  end

  always_comb begin
    state_next = state_reg;
    bitCnt_next = bitCnt_reg;
    shift_next = shift_reg;
    pointer_next = pointer_reg;
    config_next = config_reg;
    blockLen_next = blockLen_reg;
    crc_next = crc_reg;
    remain_next = remain_reg;
    armed_next = armed_reg;
    wrIdx_next = wrIdx_reg;
    isRead_next = isRead_reg;
    ara_next = ara_reg;
    inBlock_next = inBlock_reg;
    sendPec_next = sendPec_reg;
    sdaDrive_next = sdaDrive_reg;
    skipFall_next = skipFall_reg;
    regWr = 1'b0;
    regWrData = shift_reg;
    timeout_next = 1'b0;
    // idle counter: restarts on any scl edge or sda change, enabled or not, and while idle
    if ((sclRise | sclFall) | (sda ^ sdaLast_reg) | state_reg == ST_IDLE) begin
      idle_next = '0;
    end else begin
      idle_next = idle_reg + 32'd1;
    end
    if (startCond) begin
      state_next = ST_ADDR;
      bitCnt_next = 3'd7;
      sdaDrive_next = 1'b0;
      skipFall_next = 1'b1;
      if (!armed_reg) begin
        crc_next = CRC_INIT;
      end
    end else if (stopCond) begin
      state_next = ST_IDLE;
      sdaDrive_next = 1'b0;
      armed_next = 1'b0;
    end else if (idle_reg >= 32'(TIMEOUT_LIMIT)
                 && ((config_reg[SCL_TIMEOUT_BIT] && !scl) || (config_reg[SDA_TIMEOUT_BIT] && !sda))) begin
      state_next = ST_IDLE;
      sdaDrive_next = 1'b0;
      armed_next = 1'b0;
      timeout_next = 1'b1;
    end else begin
      case (state_reg)
        ST_ADDR, ST_WRITE: begin
          if (sclRise) begin
            shift_next = {shift_reg[6:0], sda};
          end
          // the fall that closes a start carries no bit
          if (sclFall && skipFall_reg) begin
            skipFall_next = 1'b0;
          end else if (sclFall) begin
            if (bitCnt_reg == 3'd0) begin
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == OWN_ADDR) begin
                  sdaDrive_next = 1'b1;
                  isRead_next = shift_reg[0];
                  ara_next = 1'b0;
                  crc_next = crcByte(crc_reg, shift_reg);
                  state_next = ST_ADDR_ACK;
                  inBlock_next = shift_reg[0] & armed_reg;
                  remain_next = 6'(blockLen_reg) + 6'd1;
                  wrIdx_next = 2'd0;
                end else if (shift_reg == {ALERT_RESPONSE_ADDR, 1'b1} && alertOe) begin
                  sdaDrive_next = 1'b1;
                  isRead_next = 1'b1;
                  ara_next = 1'b1;
                  inBlock_next = 1'b0;
                  state_next = ST_ADDR_ACK;
                end else begin
                  state_next = ST_IGNORE;
                end
              end else begin
                sdaDrive_next = 1'b1;
                crc_next = crcByte(crc_reg, shift_reg);
                state_next = ST_WRITE_ACK;
                if (wrIdx_reg == 2'd0 && shift_reg == BLOCK_READ_CMD) begin
                  armed_next = 1'b1;
                end else if (wrIdx_reg == 2'd0) begin
                  pointer_next = shift_reg;
                  armed_next = 1'b0;
                end else if (pointer_reg == BUS_TIMEOUT_CONFIG_OFFSET) begin
                  config_next = shift_reg;
                end else if (pointer_reg == BLOCK_LEN_OFFSET) begin
                  blockLen_next = (shift_reg > BLOCK_LEN_MAX) ? BLOCK_LEN_MAX : shift_reg;
                end else begin
                  regWr = 1'b1;
                end
                if (wrIdx_reg != 2'd3) begin
                  wrIdx_next = wrIdx_reg + 2'd1;
                end
              end
            end else begin
              bitCnt_next = bitCnt_reg - 3'd1;
            end
          end
        end
        ST_ADDR_ACK, ST_WRITE_ACK: begin
          if (sclFall) begin
            bitCnt_next = 3'd7;
            if (isRead_reg) begin
              state_next = ST_READ;
              shift_next = txByte;
              sdaDrive_next = ~txByte[7];
            end else begin
              state_next = ST_WRITE;
              sdaDrive_next = 1'b0;
            end
          end
        end
        ST_READ: begin
          if (sclRise && sda != shift_reg[bitCnt_reg]) begin
            state_next = ST_IGNORE;
            sdaDrive_next = 1'b0;
          end else if (sclFall) begin
            if (bitCnt_reg == 3'd0) begin
              sdaDrive_next = 1'b0;
              state_next = ST_READ_ACK;
              crc_next = crcByte(crc_reg, shift_reg);
              if (inBlock_reg && !sendPec_reg) begin
                if (remain_reg != 6'(blockLen_reg) + 6'd1) begin
                  pointer_next = pointer_reg + 8'd1;
                end
                remain_next = remain_reg - 6'd1;
                sendPec_next = (remain_reg == 6'd1);
              end
            end else begin
              bitCnt_next = bitCnt_reg - 3'd1;
              sdaDrive_next = ~shift_reg[bitCnt_reg - 3'd1];
            end
          end
        end
        ST_READ_ACK: begin
          if (sclRise) begin
            if (sda) begin
              state_next = ST_IGNORE;
              sendPec_next = 1'b0;
              inBlock_next = 1'b0;
            end
          end else if (sclFall) begin
            bitCnt_next = 3'd7;
            state_next = ST_READ;
            shift_next = txByte;
            sdaDrive_next = ~txByte[7];
          end
        end
        ST_IGNORE: begin
          sdaDrive_next = 1'b0;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      bitCnt_reg <= 3'd7;
      shift_reg <= 8'h00;
      pointer_reg <= POINTER_RESET;
      config_reg <= BUS_TIMEOUT_CONFIG_RESET;
      blockLen_reg <= BLOCK_LEN_RESET;
      crc_reg <= CRC_INIT;
      remain_reg <= 6'd0;
      armed_reg <= 1'b0;
      wrIdx_reg <= 2'd0;
      isRead_reg <= 1'b0;
      ara_reg <= 1'b0;
      inBlock_reg <= 1'b0;
      sendPec_reg <= 1'b0;
      sdaDrive_reg <= 1'b0;
      skipFall_reg <= 1'b0;
      idle_reg <= 32'd0;
      timeout_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bitCnt_reg <= bitCnt_next;
      shift_reg <= shift_next;
      pointer_reg <= pointer_next;
      config_reg <= config_next;
      blockLen_reg <= blockLen_next;
      crc_reg <= crc_next;
      remain_reg <= remain_next;
      armed_reg <= armed_next;
      wrIdx_reg <= wrIdx_next;
      isRead_reg <= isRead_next;
      ara_reg <= ara_next;
      inBlock_reg <= inBlock_next;
      sendPec_reg <= sendPec_next;
      sdaDrive_reg <= sdaDrive_next;
      skipFall_reg <= skipFall_next;
      idle_reg <= idle_next;
      timeout_reg <= timeout_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs; alert follows its cause, so it clears only once cause is gone
  // ----------------------------------------------------------------
  assign sdaOut = 1'b0;
  assign sdaOe = sdaDrive_reg;
  assign sclOut = 1'b0;
  assign sclOe = 1'b0;
  assign alertOut = 1'b0;
  assign alertOe = alertCause;
  assign pointer = pointer_reg;
  assign timeoutEvent = timeout_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_timeout_release: assert property (@(posedge clk) disable iff (rst) timeoutEvent |-> !sdaOe)
    else $error("sda held after timeout");
  a_cfg_gates_timeout: assert property (@(posedge clk) disable iff (rst)
    timeoutEvent |-> $past(config_reg[SCL_TIMEOUT_BIT] | config_reg[SDA_TIMEOUT_BIT]))
    else $error("timeout while disabled");
  a_alert_follow: assert property (@(posedge clk) disable iff (rst) alertOe == alertCause)
    else $error("alert not following cause");
  a_arb_loss: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_READ && sclRise && sda != shift_reg[bitCnt_reg]) |=> state_reg == ST_IGNORE)
    else $error("arbitration loss ignored");
  a_ara_gated: assert property (@(posedge clk) disable iff (rst) $rose(ara_reg) |-> $past(alertOe))
    else $error("alert address answered without alert");
  a_ptr_step: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_READ && sclFall && bitCnt_reg == 3'd0 && inBlock_reg && !sendPec_reg && !startCond
     && !stopCond && remain_reg != 6'(blockLen_reg) + 6'd1 && !timeout_next) |=> pointer == $past(pointer) + 8'd1)
    else $error("pointer not advanced in block");
endmodule // smbus_read_alert_timeout

// ===== include/smbus_read_pkg.sv
/*
  constants for the smbus read path: register offsets, config bit positions,
  bus codes and timeout figures. assumes a 100 MHz core clock.
*/
package smbus_read_pkg;
  // ----------------------------------------------------------------
  // registers and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] BUS_TIMEOUT_CONFIG_OFFSET = 8'h03;
  localparam logic [7:0] BUS_TIMEOUT_CONFIG_RESET = 8'h00;
  localparam int SCL_TIMEOUT_BIT = 1;
  localparam int SDA_TIMEOUT_BIT = 2;
  localparam logic [7:0] BLOCK_LEN_OFFSET = 8'h04;
  localparam logic [7:0] BLOCK_LEN_RESET = 8'h20;
  localparam logic [7:0] BLOCK_LEN_MAX = 8'h20;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  // ----------------------------------------------------------------
  // bus codes
  // ----------------------------------------------------------------
  localparam logic [7:0] BLOCK_READ_CMD = 8'hA1;
  localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0C;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
  // ----------------------------------------------------------------
  // transfer states, gray along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b011,
    ST_WRITE = 3'b010,
    ST_WRITE_ACK = 3'b110,
    ST_READ = 3'b111,
    ST_READ_ACK = 3'b101,
    ST_IGNORE = 3'b100
  } xfer_state_t;
endpackage

// ===== testbench/smbus_host_model.sv
/*
  smbus host model: drives scl, pulls sda low, reads the wired-and sda line.
  assumes the bench calls one task at a time, with the bus idle or scl low.
*/
`timescale 1ns/1ps
module smbus_host_model (
  // device side
  input wire logic devSdaOe,
  // bus lines
  output logic scl,
  output logic sdaLine
);
  logic sdaLow;
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // pulled-up line, low if either party pulls
  assign sdaLine = ~(sdaLow | devSdaOe);
  task automatic bitOut(input logic v);
    #20 sdaLow = ~v;
    #20 scl = 1'b1;
    #40 scl = 1'b0;
  endtask
  task automatic bitIn(output logic v);
    #20 sdaLow = 1'b0;
    #20 scl = 1'b1;
    #20 v = sdaLine;
    #20 scl = 1'b0;
  endtask
  task automatic busStart();
    #20 sdaLow = 1'b0;
    #20 scl = 1'b1;
    #40 sdaLow = 1'b1;
    #40 scl = 1'b0;
  endtask
  task automatic busStop();
    #20 sdaLow = 1'b1;
    #20 scl = 1'b1;
    #40 sdaLow = 1'b0;
    #40;
  endtask
  task automatic sendByte(input logic [7:0] v, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) bitOut(v[i]);
    bitIn(s);
    acked = ~s;
  endtask
  task automatic recvByte(input logic ackIt, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitIn(s);
      v[i] = s;
    end
    bitOut(~ackIt);
  endtask
endmodule // smbus_host_model

// ===== testbench/smbus_read_alert_timeout_tb_top.sv
/*
  testbench for the smbus read path: register reads, block read with pec,
  alert response and bus timeout. assumes the host model on the far side.
*/
`timescale 1ns/1ps
module smbus_read_alert_timeout_tb_top;
  import smbus_read_pkg::*;
  localparam logic [6:0] DEV = 7'h5C; // arbitrary value
  localparam logic [7:0] BLK_START = 8'h40;
  logic clk, rst, scl, sda, alertCause, a;
  logic sclOut, sclOe, sdaOut, sdaOe, alertOut, alertOe, timeoutEvent;
  logic [7:0] pointer, b;
  int failures = 0;
  int comparisons = 0;
  smbus_read_alert_timeout #(.TIMEOUT_LIMIT(200), .OWN_ADDR(DEV)) smbus_read_alert_timeout_inst (
    .clk(clk), .rst(rst), .sclIn(scl & ~sclOe), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .alertCause(alertCause), .alertOut(alertOut), .alertOe(alertOe),
    .pointer(pointer), .timeoutEvent(timeoutEvent));
  smbus_host_model smbus_host_model_inst (.devSdaOe(sdaOe), .scl(scl), .sdaLine(sda));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] v);
    logic [7:0] r;
    r = c ^ v;
    for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
    return r;
  endfunction
  task automatic sendChk(input logic [7:0] v, input logic expAck);
    smbus_host_model_inst.sendByte(v, a);
    check({7'h00, a}, {7'h00, expAck}, "ack");
  endtask
  task automatic writeReg(input logic [7:0] ptr, input logic [7:0] v, input logic withData);
    smbus_host_model_inst.busStart();
    sendChk({DEV, 1'b0}, 1'b1);
    sendChk(ptr, 1'b1);
    if (withData) sendChk(v, 1'b1);
    smbus_host_model_inst.busStop();
  endtask
  task automatic readReg(input logic [6:0] addr, input logic expAck, input logic [7:0] exp);
    smbus_host_model_inst.busStart();
    sendChk({addr, 1'b1}, expAck);
    if (expAck) begin
      smbus_host_model_inst.recvByte(1'b0, b);
      check(b, exp, "read byte");
    end
    smbus_host_model_inst.busStop();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_registers();
    check(pointer, POINTER_RESET, "pointer reset");
    check({4'h0, sclOe, sdaOe, alertOe, timeoutEvent}, 8'h00, "outputs at reset");
    check({5'h00, sclOut, sdaOut, alertOut}, 8'h00, "pin levels");
    writeReg(BUS_TIMEOUT_CONFIG_OFFSET, 8'h00, 1'b0);
    check(pointer, BUS_TIMEOUT_CONFIG_OFFSET, "pointer load");
    readReg(DEV, 1'b1, BUS_TIMEOUT_CONFIG_RESET);
    writeReg(BUS_TIMEOUT_CONFIG_OFFSET, 8'h06, 1'b1);
    readReg(DEV, 1'b1, 8'h06);
    readReg(DEV, 1'b1, 8'h06);
    readReg(7'h33, 1'b0, 8'h00);
    for (int i = 0; i < 32; i++) writeReg(BLK_START + 8'(i), 8'hC3 ^ 8'(i), 1'b1);
    readReg(DEV, 1'b1, 8'hC3 ^ 8'd31);
  endtask
  task automatic test_block(input logic [7:0] len, input logic [7:0] expCount);
    logic [7:0] crc, cnt;
    writeReg(BLOCK_LEN_OFFSET, len, 1'b1);
    writeReg(BLK_START, 8'h00, 1'b0);
    smbus_host_model_inst.busStart();
    sendChk({DEV, 1'b0}, 1'b1);
    sendChk(BLOCK_READ_CMD, 1'b1);
    smbus_host_model_inst.busStart();
    sendChk({DEV, 1'b1}, 1'b1);
    smbus_host_model_inst.recvByte(1'b1, cnt);
    check(cnt, expCount, "byte count");
    crc = crcStep(crcStep(crcStep(crcStep(CRC_INIT, {DEV, 1'b0}), BLOCK_READ_CMD), {DEV, 1'b1}), expCount);
    for (int i = 0; i < expCount; i++) begin
      smbus_host_model_inst.recvByte(1'b1, b);
      check(b, 8'hC3 ^ 8'(i), "block data");
      crc = crcStep(crc, b);
    end
    smbus_host_model_inst.recvByte(1'b0, b);
    smbus_host_model_inst.busStop();
    check(b, crc, "pec");
    check(pointer, BLK_START + expCount, "pointer after block");
  endtask
  task automatic test_alert();
    readReg(ALERT_RESPONSE_ADDR, 1'b0, 8'h00);
    @(posedge clk) #1 alertCause = 1'b1;
    @(posedge clk) #1;
    check({7'h00, alertOe}, 8'h01, "alert driven");
    readReg(ALERT_RESPONSE_ADDR, 1'b1, {DEV, 1'b1});
    check({7'h00, alertOe}, 8'h01, "alert held");
    @(posedge clk) #1 alertCause = 1'b0;
    @(posedge clk) #1;
    check({7'h00, alertOe}, 8'h00, "alert released");
  endtask
  task automatic test_timeout(input logic [7:0] cfg, input logic expFire);
    logic seen;
    logic [7:0] aw;
    seen = 1'b0;
    aw = {DEV, 1'b0};
    writeReg(BUS_TIMEOUT_CONFIG_OFFSET, cfg, 1'b1);
    smbus_host_model_inst.busStart();
    for (int i = 7; i >= 0; i--) smbus_host_model_inst.bitOut(aw[i]);
    repeat (6) @(posedge clk);
    #1;
    check({7'h00, sdaOe}, 8'h01, "ack driven");
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      if (timeoutEvent === 1'b1) seen = 1'b1;
    end
    check({7'h00, seen}, {7'h00, expFire}, "timeout event");
    check({7'h00, sdaOe}, {7'h00, ~expFire}, "sda release");
    smbus_host_model_inst.bitIn(a);
    smbus_host_model_inst.busStop();
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #900_000;
    failures++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    alertCause = 1'b0;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk) #1;
    test_registers();
    test_block(8'h03, 8'h03);
    test_block(8'h01, 8'h01);
    test_block(8'h28, BLOCK_LEN_MAX);
    test_alert();
    test_timeout(8'h00, 1'b0);
    test_timeout(8'h02, 1'b1);
    test_timeout(8'h04, 1'b1);
    final_report();
  end
endmodule // smbus_read_alert_timeout_tb_top
